/* rtl/rcbo_cfg.svh */
`ifndef RCBO_CFG_SVH
`define RCBO_CFG_SVH
// reset control byte layout
`define RCBO_POR_BIT     1
`define RCBO_BOR_BIT     0
`define RCBO_SW_BROWNOUT_ENABLE_BIT  6
`define RCBO_CTRL_W      8
`define RCBO_CTRL_RST    8'h00
// config word field positions
`define RCBO_PWR_LSB     5
`define RCBO_EN_LSB      1
`define RCBO_LVL_LSB     2
// power-on reset stretch, in cycles
`define RCBO_POR_HOLD    4'h8
`endif

/* rtl/rcbo_pkg.sv */
package rcbo_pkg;
   typedef enum logic [1:0] {
      RCBO_PWR_HIGH = 2'h0,
      RCBO_PWR_MED  = 2'h1,
      RCBO_PWR_LOW  = 2'h2,
      RCBO_PWR_ZERO = 2'h3
   } rcbo_pwr_t;
   typedef enum logic [1:0] {
      RCBO_EN_OFF   = 2'h0,
      RCBO_EN_SW    = 2'h1,
      RCBO_EN_RUN   = 2'h2,
      RCBO_EN_ON    = 2'h3
   } rcbo_en_t;
   typedef struct packed {
      rcbo_pwr_t   brownout_power_sel;
      logic [1:0]  brownout_level_sel;
      rcbo_en_t    brownout_enable_cfg;
   } rcbo_cfg_t;
   typedef struct packed {
      logic sw_brownout_enable;
      logic power_on_flag;
      logic brownout_flag;
      logic write_error_flag;
   } rcbo_stat_t;
endpackage : rcbo_pkg

/* rtl/rcbo_hold.sv */
`include "rcbo_cfg.svh"
// stretches a reset request into a held reset pulse
module rcbo_hold
   import rcbo_pkg::*;
(
   input  wire logic ref_clk_in,
   input  wire logic reset_in,
   input  wire logic trig_in,
   output logic      hold_out
);
   logic [3:0] cnt_q;
   // load on trigger, count down to zero
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         cnt_q <= `RCBO_POR_HOLD;
      end else if (trig_in) begin
         cnt_q <= `RCBO_POR_HOLD;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
   assign hold_out = (cnt_q != 4'h0);
endmodule // rcbo_hold

/* rtl/rcbo_top.sv */
// How it works
// - supply rising above threshold while armed asserts internal power-on reset
// - power-on reset clears the power-on flag; no other reset clears it, only a software write of zero
// - hardware never sets the power-on flag; software writes one
// - two-bit power select picks high, medium, low or zero-power mode
// - in high, medium, low modes the level select sets the trip point
// - every brown-out event re-arms the power-on detector
// - brown-out enabled by enable config field; software enable bit counts in software mode only, sleep gates run mode
// - zero-power mode only re-arms the detector, never resets
// - brown-out flag cleared on brown-out reset and on power-on reset
// - low-power brown-out is not recorded in the brown-out flag
// - flash write cut by pin or watchdog reset sets write-error flag
`include "rcbo_cfg.svh"
module rcbo_top
   import rcbo_pkg::*;
(
   input  wire logic       ref_clk_in,
   input  wire logic       reset_in,
   input  wire rcbo_cfg_t  cfg_in,
   input  wire logic       supply_ok_in,
   input  wire logic [3:0] level_trip_in,
   input  wire logic       zero_power_monitor_in,
   input  wire logic       sleep_in,
   input  wire logic       ext_pin_reset_in,
   input  wire logic       watchdog_reset_in,
   input  wire logic       flash_write_busy_in,
   input  wire logic       wr_en_in,
   input  wire rcbo_stat_t wr_data_in,
   output rcbo_stat_t      status_out,
   output logic            brownout_event_out,
   output logic            sys_reset_out
);
   // ----------------------------------------------------------------
   // brown-out detection
   // ----------------------------------------------------------------
   logic       armed_q;
   logic       sw_en_q;
   logic       por_flag_q;
   logic       bor_flag_q;
   logic       write_error_flag_q;
   logic       bor_en;
   logic       below_lvl;
   logic       bor_evt;
   logic       bor_rst;
   logic       por_trig;
   logic       por_hold;
   logic       below_q;
   logic       supply_q;

   // enable resolution
   // enable resolution
   always_comb begin
      unique case (cfg_in.brownout_enable_cfg)
         RCBO_EN_OFF: bor_en = 1'b0;
         RCBO_EN_SW:  bor_en = sw_en_q;
         RCBO_EN_RUN: bor_en = ~sleep_in;
         RCBO_EN_ON:  bor_en = 1'b1;
      endcase
   end

   // selected trip comparator, or zero-power monitor
   // mode selects source
   assign below_lvl = (cfg_in.brownout_power_sel == RCBO_PWR_ZERO) ? zero_power_monitor_in
                    : level_trip_in[cfg_in.brownout_level_sel];

   // rising edge of the below-level condition is one event
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         below_q <= 1'b0;
      end else begin
         below_q <= below_lvl & bor_en;
      end
   end
   assign bor_evt = below_lvl & bor_en & ~below_q;
   assign bor_rst = bor_evt & (cfg_in.brownout_power_sel != RCBO_PWR_ZERO)
                    & (cfg_in.brownout_power_sel != RCBO_PWR_LOW);
   assign brownout_event_out = bor_evt;

   // ----------------------------------------------------------------
   // power-on detector
   // ----------------------------------------------------------------
   // previous supply level, low before power-up
   // a re-arm alone must not fire while the supply stays good
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         supply_q <= 1'b0;
      end else begin
         supply_q <= supply_ok_in;
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         armed_q <= 1'b1;
      end else if (bor_evt | ~supply_ok_in) begin
         armed_q <= 1'b1;
      end else if (por_trig) begin
         armed_q <= 1'b0;
      end
   end
   // supply rise fires
   // only a rising supply seen while armed starts a power-on reset
   assign por_trig = armed_q & supply_ok_in & ~supply_q;

   rcbo_hold u_hold (
      .ref_clk_in (ref_clk_in),
      .reset_in   (reset_in),
      .trig_in    (por_trig | bor_rst),
      .hold_out   (por_hold)
   );
   // trigger cycle included so a supply rise leaves no release gap
   assign sys_reset_out = por_hold | por_trig | ~supply_ok_in;

   // ----------------------------------------------------------------
   // reset cause flags
   // ----------------------------------------------------------------
   // power-on clears flag
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         por_flag_q <= 1'b0;
      end else if (por_trig) begin
         por_flag_q <= 1'b0;
      end else if (wr_en_in) begin
         por_flag_q <= wr_data_in.power_on_flag;
      end
   end
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         bor_flag_q <= 1'b0;
      end else if (por_trig | bor_rst) begin
         bor_flag_q <= 1'b0;
      end else if (wr_en_in) begin
         bor_flag_q <= wr_data_in.brownout_flag;
      end
   end
   // software enable resets to on so software mode starts protected
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         sw_en_q <= 1'b1;
      end else if (por_trig) begin
         sw_en_q <= 1'b1;
      end else if (wr_en_in) begin
         sw_en_q <= wr_data_in.sw_brownout_enable;
      end
   end
   // interrupted write error, set wins over clear
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         write_error_flag_q <= 1'b0;
      end else if (flash_write_busy_in & (ext_pin_reset_in | watchdog_reset_in)) begin
         write_error_flag_q <= 1'b1;
      end else if (por_trig) begin
         write_error_flag_q <= 1'b0;
      end else if (wr_en_in) begin
         write_error_flag_q <= wr_data_in.write_error_flag;
      end
   end

   assign status_out = '{sw_brownout_enable: sw_en_q, power_on_flag: por_flag_q,
                         brownout_flag: bor_flag_q, write_error_flag: write_error_flag_q};

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // clear after por
   por_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      por_trig |=> !por_flag_q) else $error("power-on flag not cleared");
   por_noset_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      !$past(wr_en_in) && !$past(por_flag_q) |-> !por_flag_q)
      else $error("power-on flag set by hardware");
   bor_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      bor_rst |=> !bor_flag_q) else $error("brown-out flag not cleared");
   zero_norst_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      cfg_in.brownout_power_sel == RCBO_PWR_ZERO |-> !bor_rst)
      else $error("zero-power mode reset");
   low_norec_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      bor_evt && cfg_in.brownout_power_sel == RCBO_PWR_LOW && !por_trig && !wr_en_in
      && bor_flag_q |=> bor_flag_q) else $error("low-power event recorded");
   rearm_evt_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      bor_evt |=> armed_q) else $error("detector not re-armed");
   sw_ignore_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      cfg_in.brownout_enable_cfg == RCBO_EN_OFF |-> !bor_evt)
      else $error("brown-out fired while disabled");
   write_error_flag_set_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      flash_write_busy_in && watchdog_reset_in |=> write_error_flag_q)
      else $error("write error not flagged");
   por_hold_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      por_trig |=> sys_reset_out[*7]) else $error("power-on reset too short");
   rise_hold_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      !supply_ok_in |=> sys_reset_out) else $error("reset released on supply rise");
   por_only_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      !por_trig && !wr_en_in && por_flag_q |=> por_flag_q)
      else $error("power-on flag cleared without power-on reset");
   bor_por_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      por_trig |=> !bor_flag_q)
      else $error("brown-out flag kept over power-on reset");
   sw_gate_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      cfg_in.brownout_enable_cfg == RCBO_EN_SW && !sw_en_q |-> !bor_evt)
      else $error("brown-out fired with software enable off");
   pin_write_error_flag_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      flash_write_busy_in && ext_pin_reset_in |=> write_error_flag_q)
      else $error("write error not flagged on pin reset");

   // ----------------------------------------------------------------
   // cover points
   // ----------------------------------------------------------------
   bor_reset_c: cover property (@(posedge ref_clk_in) disable iff (reset_in) bor_rst);
   zero_rearm_c: cover property (@(posedge ref_clk_in) disable iff (reset_in)
      bor_evt && cfg_in.brownout_power_sel == RCBO_PWR_ZERO);
   write_error_flag_c: cover property (@(posedge ref_clk_in) disable iff (reset_in) $rose(write_error_flag_q));
   sw_en_c: cover property (@(posedge ref_clk_in) disable iff (reset_in)
      bor_evt && cfg_in.brownout_enable_cfg == RCBO_EN_SW);
   low_evt_c: cover property (@(posedge ref_clk_in) disable iff (reset_in)
      bor_evt && cfg_in.brownout_power_sel == RCBO_PWR_LOW);
endmodule // rcbo_top

/* sim/rcbo_tb.sv */
module testbench
   import rcbo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       ref_clk_in = 1'b0;
   logic       reset_in, supply_ok_in, zero_power_monitor_in, sleep_in;
   logic       ext_pin_reset_in, watchdog_reset_in, flash_write_busy_in, wr_en_in;
   logic       brownout_event_out, sys_reset_out;
   logic [3:0] level_trip_in;
   rcbo_cfg_t  cfg_in;
   rcbo_stat_t wr_data_in, status_out;
   int         failures = 0;
   int         compares = 0;

   // ----------------------------------------
   // clock and device
   // ----------------------------------------
   always #2 ref_clk_in = ~ref_clk_in;

   rcbo_top uut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .cfg_in(cfg_in),
      .supply_ok_in(supply_ok_in), .level_trip_in(level_trip_in),
      .zero_power_monitor_in(zero_power_monitor_in), .sleep_in(sleep_in),
      .ext_pin_reset_in(ext_pin_reset_in), .watchdog_reset_in(watchdog_reset_in),
      .flash_write_busy_in(flash_write_busy_in), .wr_en_in(wr_en_in),
      .wr_data_in(wr_data_in), .status_out(status_out),
      .brownout_event_out(brownout_event_out), .sys_reset_out(sys_reset_out));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic conclude;
      $display("counts: compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(string n, logic e, logic g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask

   // bounded wait for the internal reset to drop
   task automatic settle;
      int n;
      n = 0;
      @(negedge ref_clk_in);
      while (sys_reset_out !== 1'b0) begin
         n++;
         if (n > 40) begin
            chk("settle", 1'b0, sys_reset_out);
            conclude;
         end
         @(negedge ref_clk_in);
      end
   endtask

   task automatic wr(rcbo_stat_t d);
      @(posedge ref_clk_in);
      wr_en_in   <= 1'b1;
      wr_data_in <= d;
      @(posedge ref_clk_in);
      wr_en_in   <= 1'b0;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // brown-out crossing under one mode and enable setting
   task automatic bo(rcbo_pwr_t p, rcbo_en_t e, logic sw, logic [1:0] sel, logic [1:0] t,
                     logic sl, logic x);
      logic r;
      r = x && (p != RCBO_PWR_LOW);
      settle;
      wr('{sw, 1'b1, 1'b1, 1'b0});
      @(posedge ref_clk_in);
      cfg_in   <= '{p, sel, e};
      sleep_in <= sl;
      @(posedge ref_clk_in);
      level_trip_in <= 4'h1 << t;
      @(negedge ref_clk_in);
      chk("event", x, brownout_event_out);
      @(posedge ref_clk_in);
      level_trip_in <= 4'h0;
      @(negedge ref_clk_in);
      chk("bor flag", !r, status_out.brownout_flag);
      @(negedge ref_clk_in);
      chk("reset", r, sys_reset_out);
      settle;
      chk("por flag", 1'b1, status_out.power_on_flag);
   endtask

   // reset cause during a flash write
   task automatic wre(logic pin, logic wd, logic busy);
      settle;
      wr('{1'b1, 1'b1, 1'b1, 1'b0});
      @(posedge ref_clk_in);
      flash_write_busy_in <= busy;
      ext_pin_reset_in    <= pin;
      watchdog_reset_in   <= wd;
      @(posedge ref_clk_in);
      flash_write_busy_in <= 1'b0;
      ext_pin_reset_in    <= 1'b0;
      watchdog_reset_in   <= 1'b0;
      @(negedge ref_clk_in);
      chk("wr err", busy, status_out.write_error_flag);
      chk("por kept", 1'b1, status_out.power_on_flag);
      chk("bor kept", 1'b1, status_out.brownout_flag);
   endtask

   // supply dip below the power-on threshold and back
   task automatic pd;
      settle;
      wr('{1'b0, 1'b1, 1'b1, 1'b1});
      @(posedge ref_clk_in);
      supply_ok_in <= 1'b0;
      @(negedge ref_clk_in);
      chk("dip reset", 1'b1, sys_reset_out);
      chk("dip por", 1'b1, status_out.power_on_flag);
      @(posedge ref_clk_in);
      supply_ok_in <= 1'b1;
      @(negedge ref_clk_in);
      chk("rise reset", 1'b1, sys_reset_out);
      @(negedge ref_clk_in);
      chk("rise por", 1'b0, status_out.power_on_flag);
      chk("rise bor", 1'b0, status_out.brownout_flag);
      chk("rise sw en", 1'b1, status_out.sw_brownout_enable);
      chk("rise wr err", 1'b0, status_out.write_error_flag);
      settle;
   endtask

   // zero-power monitor only re-arms, a later supply rise resets
   task automatic zp;
      settle;
      wr('{1'b1, 1'b1, 1'b1, 1'b0});
      @(posedge ref_clk_in);
      cfg_in <= '{RCBO_PWR_ZERO, 2'h0, RCBO_EN_ON};
      @(posedge ref_clk_in);
      zero_power_monitor_in <= 1'b1;
      @(negedge ref_clk_in);
      chk("zp event", 1'b1, brownout_event_out);
      @(posedge ref_clk_in);
      zero_power_monitor_in <= 1'b0;
      @(negedge ref_clk_in);
      chk("zp bor", 1'b1, status_out.brownout_flag);
      chk("zp no reset", 1'b0, sys_reset_out);
      @(negedge ref_clk_in);
      chk("zp por kept", 1'b1, status_out.power_on_flag);
      pd;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      reset_in = 1'b1;
      supply_ok_in = 1'b1;
      zero_power_monitor_in = 1'b0;
      sleep_in = 1'b0;
      ext_pin_reset_in = 1'b0;
      watchdog_reset_in = 1'b0;
      flash_write_busy_in = 1'b0;
      wr_en_in = 1'b0;
      level_trip_in = 4'h0;
      cfg_in = '{RCBO_PWR_HIGH, 2'h0, RCBO_EN_OFF};
      wr_data_in = '0;
      repeat (12) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      @(negedge ref_clk_in);
      chk("cold reset", 1'b1, sys_reset_out);
      settle;
      chk("por cold", 1'b0, status_out.power_on_flag);
      chk("bor cold", 1'b0, status_out.brownout_flag);
      chk("sw en cold", 1'b1, status_out.sw_brownout_enable);
      wr('{1'b1, 1'b1, 1'b0, 1'b0});
      @(negedge ref_clk_in);
      chk("por set", 1'b1, status_out.power_on_flag);
      bo(RCBO_PWR_HIGH, RCBO_EN_ON, 1'b1, 2'h0, 2'h0, 1'b0, 1'b1);
      bo(RCBO_PWR_MED, RCBO_EN_ON, 1'b1, 2'h3, 2'h3, 1'b0, 1'b1);
      bo(RCBO_PWR_HIGH, RCBO_EN_ON, 1'b1, 2'h2, 2'h1, 1'b0, 1'b0);
      bo(RCBO_PWR_HIGH, RCBO_EN_OFF, 1'b1, 2'h1, 2'h1, 1'b0, 1'b0);
      bo(RCBO_PWR_HIGH, RCBO_EN_SW, 1'b0, 2'h2, 2'h2, 1'b0, 1'b0);
      bo(RCBO_PWR_HIGH, RCBO_EN_SW, 1'b1, 2'h2, 2'h2, 1'b0, 1'b1);
      bo(RCBO_PWR_HIGH, RCBO_EN_RUN, 1'b0, 2'h1, 2'h1, 1'b1, 1'b0);
      bo(RCBO_PWR_LOW, RCBO_EN_RUN, 1'b0, 2'h1, 2'h1, 1'b0, 1'b1);
      bo(RCBO_PWR_ZERO, RCBO_EN_ON, 1'b1, 2'h1, 2'h1, 1'b0, 1'b0);
      wre(1'b1, 1'b0, 1'b1);
      wre(1'b0, 1'b1, 1'b1);
      wre(1'b1, 1'b0, 1'b0);
      zp;
      conclude;
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      chk("timeout", 1'b0, 1'b1);
      conclude;
   end
endmodule // testbench
